// File: design/rlsc_regs.vh
// constants for the retimer link-state controller
// assumes a 20 MHz system clock
`ifndef RLSC_REGS_VH
`define RLSC_REGS_VH

`define RLSC_CLK_HZ 20000000
// timer periods in microseconds
`define RLSC_ACTIVE_US 12000
`define RLSC_CONFIG_US 12000
`define RLSC_IDLE_US 2000
`define RLSC_PING_US 300000
`define RLSC_NOLFPS_US 2000
`define RLSC_WARM_US 2000
// microseconds to cycles, exact multiply, no rounding
`define RLSC_CYC(us) ((us) * (`RLSC_CLK_HZ / 1000000))
`define RLSC_ACTIVE_TRIES 2'h3
// u2 inactivity timeout unit in cycles
`define RLSC_U2_UNIT 32'h0001_0000
// link configuration field bits
`define RLSC_LC_RESET 0
`define RLSC_LC_LPBK 2
`define RLSC_LC_NOSCR 3
`define RLSC_LC_LOCAL 4
// state codes, one-hot except error, which is all zeros
`define RLSC_NST 11
`define RLSC_S_RXDET 11'h001
`define RLSC_S_TSX 11'h002
`define RLSC_S_IDLE 11'h004
`define RLSC_S_U0 11'h008
`define RLSC_S_U1 11'h010
`define RLSC_S_U2 11'h020
`define RLSC_S_U3 11'h040
`define RLSC_S_REC 11'h080
`define RLSC_S_HOTRST 11'h100
`define RLSC_S_PTLB 11'h200
`define RLSC_S_LOCLB 11'h400
`define RLSC_S_ERR 11'h000

`endif

// File: design/rlsc_top.v
// link-state controller of a clock-recovering repeater, tsx/idle/u0/u1
// assumes link events are decoded upstream and synchronous to clk_sys
//
// Operation
// - tracking needs polarity done, follows partner training
// - compensation method chosen by gen1 or ssp
// - scrambler sync and dc balance kept
// - training sets forwarded without any correction
// - active timer on entry, config on both ts2
// - ts2 handshake moves tracking to idle
// - three active timeouts disable transceivers until warm
// - warm reset, or active timeout once ts1 or ts2 seen, goes detect
// - decode config, set scrambler, no idle deletion
// - idle timer; warm or expiry goes detect
// - idle handshake to u0, reset bit hot reset
// - bit 2 passthrough, bit 4 local, 2 wins
// - decode link commands, orientation, u2 timeout lmp
// - no recovery on errors, send idles meanwhile
// - u0 error correction per generation
// - lgo sequences to u1/u2/u3, ts1 recovery
// - u1 lfps: exit handshake, forward, time warm
// - u2 inactivity timer only when nonzero
// - 300 ms ping timeout restarted per ping
// - own upstream pings; expiry disconnects and detects
// - u1 exit handshake to recovery, warm detect
// - no-lfps-response expiry returns to detect
// - long lfps forwarded before warm declared
`timescale 1ns/1ps
`include "rlsc_regs.vh"
`default_nettype none

module rlsc_top #(
    parameter [31:0] ACTIVE_CYC = `RLSC_CYC(`RLSC_ACTIVE_US),
    parameter [31:0] CONFIG_CYC = `RLSC_CYC(`RLSC_CONFIG_US),
    parameter [31:0] IDLE_CYC = `RLSC_CYC(`RLSC_IDLE_US),
    parameter [31:0] PING_CYC = `RLSC_CYC(`RLSC_PING_US),
    parameter [31:0] NOLFPS_CYC = `RLSC_CYC(`RLSC_NOLFPS_US),
    parameter [31:0] WARM_CYC = `RLSC_CYC(`RLSC_WARM_US)
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // training inputs
    input wire enter_tsx,
    input wire polarity_done,
    input wire ssp_mode,
    input wire ts2_both_seen,
    input wire ts2_handshake,
    input wire ts1_seen,
    input wire [7:0] link_config,
    input wire idle_handshake,
    // u0 inputs
    input wire lgo_u1_done,
    input wire lgo_u2_done,
    input wire lgo_u3_done,
    input wire lock_lost,
    input wire lmp_init_seen,
    input wire lmp_from_down,
    input wire u2_lmp_acked,
    input wire [7:0] u2_lmp_value,
    // lfps inputs
    input wire lfps_active,
    input wire lfps_is_ping,
    input wire ping_rx,
    input wire u1_exit_done,
    input wire warm_reset_in,
    // outputs
    output reg [`RLSC_NST-1:0] state_q,
    output reg xcvr_enable_q,
    output reg scrambler_en_q,
    output reg comp_ssp_q,
    output reg idle_delete_en_q,
    output reg forward_ts_raw_q,
    output reg err_correct_en_q,
    output reg send_idles_q,
    output reg port_flip_q,
    output reg [7:0] u2_timeout_q,
    output reg exit_lfps_tx_q,
    output reg lfps_forward_q,
    output reg warm_declared_q,
    output reg ping_tx_en_q,
    output reg us_term_en_q,
    output reg disconnect_q,
    output reg cfg_timer_run_q
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function hit;
        input [31:0] cnt;
        input [31:0] lim;
        begin
            hit = (cnt >= lim - 32'h0000_0001);
        end
    endfunction

    // u2 inactivity limit in cycles
    function [31:0] u2_limit;
        input [7:0] tmo;
        begin
            u2_limit = {24'h00_0000, tmo} * `RLSC_U2_UNIT;
        end
    endfunction

    reg [`RLSC_NST-1:0] state_d;
    reg [31:0] tmr_q;
    reg [31:0] tmr2_q;
    reg [31:0] lfps_len_q;
    reg [1:0] tries_q;
    reg hs_seen_q;
    // declared warm acts as a received one
    wire warm = warm_reset_in | warm_declared_q;
    // inbound lfps that is not a ping
    wire lfps_exit_in = lfps_active & ~lfps_is_ping;
    wire in_tsx = (state_q == `RLSC_S_TSX);
    wire in_idle = (state_q == `RLSC_S_IDLE);
    wire in_u0 = (state_q == `RLSC_S_U0);
    wire in_u1 = (state_q == `RLSC_S_U1);
    wire u2_tmr_on = (u2_timeout_q != 8'h00);
    wire act_exp = in_tsx & hit(tmr_q, ACTIVE_CYC);
    wire idle_exp = in_idle & hit(tmr_q, IDLE_CYC);
    wire ping_exp = in_u1 & hit(tmr_q, PING_CYC);
    wire nolfps_exp = in_u1 & exit_lfps_tx_q & hit(tmr2_q, NOLFPS_CYC);
    wire u2_exp = in_u1 & u2_tmr_on & ~exit_lfps_tx_q & (tmr2_q >= u2_limit(u2_timeout_q));
    // ping timeout that really leaves u1
    wire disc_now = ping_exp & ~warm & ~u1_exit_done;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always @* begin
        state_d = state_q;
        case (state_q)
            `RLSC_S_RXDET: begin
                if (enter_tsx & polarity_done) begin
                    state_d = `RLSC_S_TSX;
                end
            end
            `RLSC_S_TSX: begin
                if (ts2_handshake) begin
                    state_d = `RLSC_S_IDLE;
                end else if (act_exp & (tries_q == `RLSC_ACTIVE_TRIES - 2'h1) & ~hs_seen_q) begin
                    state_d = `RLSC_S_ERR;
                end else if (act_exp & hs_seen_q) begin
                    state_d = `RLSC_S_RXDET;
                end
            end
            `RLSC_S_IDLE: begin
                if (link_config[`RLSC_LC_LPBK]) begin
                    state_d = `RLSC_S_PTLB;
                end else if (link_config[`RLSC_LC_LOCAL]) begin
                    state_d = `RLSC_S_LOCLB;
                end else if (link_config[`RLSC_LC_RESET]) begin
                    state_d = `RLSC_S_HOTRST;
                end else if (idle_handshake) begin
                    state_d = `RLSC_S_U0;
                end else if (idle_exp) begin
                    state_d = `RLSC_S_RXDET;
                end
            end
            `RLSC_S_U0: begin
                if (ts1_seen) begin
                    state_d = `RLSC_S_REC;
                end else if (lgo_u1_done) begin
                    state_d = `RLSC_S_U1;
                end else if (lgo_u2_done) begin
                    state_d = `RLSC_S_U2;
                end else if (lgo_u3_done) begin
                    state_d = `RLSC_S_U3;
                end
            end
            `RLSC_S_U1: begin
                if (u1_exit_done) begin
                    state_d = `RLSC_S_REC;
                end else if (ping_exp | nolfps_exp) begin
                    state_d = `RLSC_S_RXDET;
                end else if (u2_exp) begin
                    state_d = `RLSC_S_U2;
                end
            end
            `RLSC_S_U2, `RLSC_S_U3, `RLSC_S_REC, `RLSC_S_HOTRST,
            `RLSC_S_PTLB, `RLSC_S_LOCLB, `RLSC_S_ERR: begin
                state_d = state_q;
            end
            default: begin
                state_d = `RLSC_S_RXDET;
            end
        endcase
        if (warm) begin
            state_d = `RLSC_S_RXDET;
        end
    end

    // ----------------------------------------
    // state and timers
    // ----------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= `RLSC_S_RXDET;
            tmr_q <= 32'h0000_0000;
            tmr2_q <= 32'h0000_0000;
            tries_q <= 2'h0;
            hs_seen_q <= 1'b0;
            cfg_timer_run_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if ((state_d != state_q) | act_exp | (in_u1 & ping_rx)) begin
                tmr_q <= 32'h0000_0000;
            end else begin
                tmr_q <= tmr_q + 32'h0000_0001;
            end
            if ((state_d != state_q) | (in_u1 & lfps_active & ~lfps_is_ping & ~exit_lfps_tx_q)) begin
                tmr2_q <= 32'h0000_0000;
            end else begin
                tmr2_q <= tmr2_q + 32'h0000_0001;
            end
            if (~in_tsx) begin
                tries_q <= 2'h0;
            end else if (act_exp) begin
                tries_q <= tries_q + 2'h1;
            end
            if (~in_tsx) begin
                hs_seen_q <= 1'b0;
            end else if (ts2_both_seen | ts1_seen) begin
                hs_seen_q <= 1'b1;
            end
            cfg_timer_run_q <= in_tsx & (cfg_timer_run_q | ts2_both_seen);
        end
    end

    // ----------------------------------------
    // data path controls
    // ----------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            xcvr_enable_q <= 1'b1;
            scrambler_en_q <= 1'b1;
            comp_ssp_q <= 1'b0;
            idle_delete_en_q <= 1'b0;
            forward_ts_raw_q <= 1'b0;
            err_correct_en_q <= 1'b0;
            send_idles_q <= 1'b0;
            port_flip_q <= 1'b0;
            u2_timeout_q <= 8'h00;
        end else begin
            xcvr_enable_q <= ~(state_d == `RLSC_S_ERR);
            comp_ssp_q <= ssp_mode;
            if (in_idle) begin
                scrambler_en_q <= ~link_config[`RLSC_LC_NOSCR];
            end
            idle_delete_en_q <= ~(state_d == `RLSC_S_IDLE) & ~ssp_mode;
            forward_ts_raw_q <= (state_d == `RLSC_S_TSX);
            err_correct_en_q <= (state_d == `RLSC_S_U0);
            send_idles_q <= (state_d == `RLSC_S_U0) & lock_lost;
            if (in_u0 & lmp_init_seen) begin
                port_flip_q <= lmp_from_down;
            end
            if (in_u0 & u2_lmp_acked) begin
                u2_timeout_q <= u2_lmp_value;
            end
        end
    end

    // ----------------------------------------
    // lfps handling
    // ----------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            exit_lfps_tx_q <= 1'b0;
            lfps_forward_q <= 1'b0;
            lfps_len_q <= 32'h0000_0000;
            warm_declared_q <= 1'b0;
        end else begin
            if (~in_u1 | (state_d != state_q)) begin
                exit_lfps_tx_q <= 1'b0;
            end else if (lfps_exit_in) begin
                exit_lfps_tx_q <= 1'b1;
            end
            lfps_forward_q <= lfps_exit_in;
            if (lfps_exit_in) begin
                lfps_len_q <= lfps_len_q + 32'h0000_0001;
            end else begin
                lfps_len_q <= 32'h0000_0000;
            end
            // one pulse per long lfps, and one more each time the 32-bit lfps_len_q wraps
            warm_declared_q <= lfps_exit_in & (lfps_len_q == WARM_CYC - 32'h0000_0001);
        end
    end

    // ----------------------------------------
    // ping and disconnect
    // ----------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ping_tx_en_q <= 1'b0;
            us_term_en_q <= 1'b1;
            disconnect_q <= 1'b0;
        end else begin
            ping_tx_en_q <= (state_d == `RLSC_S_U1);
            disconnect_q <= disc_now;
            if (disc_now) begin
                us_term_en_q <= 1'b0;
            end else if (enter_tsx) begin
                us_term_en_q <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// File: verification/rlsc_checker.sv
// checker for the link-state controller
// assumes it is bound onto rlsc_top and sees only its ports
`timescale 1ns/1ps
`include "rlsc_regs.vh"
`default_nettype none
module rlsc_checker #(parameter [31:0] PING_CYC = 32'h0000_0040) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // events in
    input wire enter_tsx,
    input wire polarity_done,
    input wire ts2_handshake,
    input wire [7:0] link_config,
    input wire idle_handshake,
    input wire ts1_seen,
    input wire lfps_active,
    input wire lfps_is_ping,
    input wire ping_rx,
    input wire warm_reset_in,
    // state and flags out
    input wire [10:0] state_q,
    input wire forward_ts_raw_q,
    input wire err_correct_en_q,
    input wire exit_lfps_tx_q,
    input wire lfps_forward_q,
    input wire warm_declared_q,
    input wire ping_tx_en_q,
    input wire us_term_en_q,
    input wire disconnect_q
);
default clocking cb @(posedge clk_sys); endclocking
default disable iff (!rst_n);
wire w = warm_reset_in | warm_declared_q;
wire [10:0] s = state_q;
wire lc_any = link_config[0] | link_config[2] | link_config[4];
// ---------------------------------------------
// cycles in standby since entry or last ping
// ---------------------------------------------
reg [31:0] ping_cnt_q;
wire [31:0] ping_cnt_d = (s != `RLSC_S_U1 || ping_rx) ? 32'h0 : ping_cnt_q + 32'h1;
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) ping_cnt_q <= 32'h0;
    else ping_cnt_q <= ping_cnt_d;
end
// ---------------------------------------------
// assertions
// ---------------------------------------------
AST_TSX_ENTRY: assert property (s == `RLSC_S_RXDET && enter_tsx && polarity_done && !w
    |=> s == `RLSC_S_TSX) else $error("tracking not entered");
AST_TSX_RAW: assert property (s == `RLSC_S_TSX |-> forward_ts_raw_q)
    else $error("training sets not raw");
AST_TS2_IDLE: assert property (s == `RLSC_S_TSX && ts2_handshake && !w |=> s == `RLSC_S_IDLE)
    else $error("no idle after handshake");
AST_PASSTHRU: assert property (s == `RLSC_S_IDLE && link_config[2] && !w |=> s == `RLSC_S_PTLB)
    else $error("pass-through not taken");
AST_IDLE_U0: assert property (s == `RLSC_S_IDLE && idle_handshake && !lc_any && !w
    |=> s == `RLSC_S_U0 ##0 err_correct_en_q) else $error("u0 not entered");
AST_U0_TS1: assert property (s == `RLSC_S_U0 && ts1_seen && !w |=> s == `RLSC_S_REC)
    else $error("ts1 did not start recovery");
AST_U1_EXIT: assert property (s == `RLSC_S_U1 && lfps_active && !lfps_is_ping && !w
    && !exit_lfps_tx_q && ping_cnt_q != PING_CYC - 32'h1
    |=> exit_lfps_tx_q && lfps_forward_q) else $error("exit lfps missing");
AST_WARM: assert property (w |=> s == `RLSC_S_RXDET)
    else $error("warm reset ignored");
AST_WARM_DECL: assert property (warm_declared_q |=> s == `RLSC_S_RXDET)
    else $error("declared warm kept state");
AST_DISC: assert property (disconnect_q |-> !us_term_en_q && !ping_tx_en_q)
    else $error("disconnect left termination on");
AST_PING_TMO: assert property (ping_cnt_q <= PING_CYC)
    else $error("ping timeout overran");
COV_U0: cover property (s == `RLSC_S_U0);
COV_DISC: cover property (disconnect_q);
COV_WARM: cover property (warm_declared_q);
COV_U2: cover property (s == `RLSC_S_U2);
endmodule
bind rlsc_top rlsc_checker #(.PING_CYC(PING_CYC)) chk_u (.*);
`default_nettype wire

// File: verification/rlsc_partner.sv
// link partner model: upstream pings and exit handshake answers
// assumes drive 1 ns after the rising clock edge, ahead of the bench
`timescale 1ns/1ps
`default_nettype none
module rlsc_partner #(parameter int PERIOD = 20) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // control from bench
    input wire logic ping_on,
    input wire logic resp_on,
    // link side
    input wire logic exit_lfps_tx_q,
    output var logic ping_rx,
    output var logic u1_exit_done
);
int cnt = 0;
initial begin
    ping_rx = 0;
    u1_exit_done = 0;
end
always @(posedge clk_sys) begin
    #1;
    cnt = (ping_on && rst_n && cnt < PERIOD) ? cnt + 1 : 0;
    ping_rx = ping_on && cnt == PERIOD;
    u1_exit_done = resp_on && exit_lfps_tx_q;
end
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench for the link-state controller
// assumes the design, its header and the partner model compiled first
`timescale 1ns/1ps
`include "rlsc_regs.vh"
`default_nettype none
module tb_top;
localparam int PING = 60, NOL = 30, WARM = 16, ACT = 40, IDL = 30;
logic clk_sys = 0, rst_n = 0, enter_tsx, polarity_done, ssp_mode, ts2_both_seen, ts2_handshake;
logic ts1_seen, idle_handshake, lgo_u1_done, lgo_u2_done, lgo_u3_done, lock_lost, lmp_init_seen;
logic lmp_from_down, u2_lmp_acked, lfps_active, lfps_is_ping, warm_reset_in, ping_on, resp_on;
logic ping_rx, u1_exit_done, xcvr_enable_q, scrambler_en_q, comp_ssp_q, idle_delete_en_q;
logic forward_ts_raw_q, err_correct_en_q, send_idles_q, port_flip_q, exit_lfps_tx_q;
logic lfps_forward_q, warm_declared_q, ping_tx_en_q, us_term_en_q, disconnect_q, cfg_timer_run_q;
logic [7:0] link_config, u2_lmp_value, u2_timeout_q, lc;
logic [10:0] state_q;
int fails = 0, checks_done = 0, k;
always #25 clk_sys = ~clk_sys;
rlsc_top #(.ACTIVE_CYC(ACT), .CONFIG_CYC(ACT), .IDLE_CYC(IDL), .PING_CYC(PING),
    .NOLFPS_CYC(NOL), .WARM_CYC(WARM)) dut_u (.*);
rlsc_partner #(.PERIOD(PING / 3)) pm_u (.*);
task tick(input int n); repeat (n) @(posedge clk_sys); #2; endtask
task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
        fails++;
        $display("wrong value %s expected %h seen %h", nm, e, g);
    end
endtask
task wait_st(input logic [10:0] e, input int lim);
    for (int i = 0; i < lim && state_q !== e; i++) tick(1);
    chk("state", e, state_q);
endtask
function automatic logic [10:0] exp_idle(input logic [7:0] v);
    if (v[2]) return `RLSC_S_PTLB;
    if (v[4]) return `RLSC_S_LOCLB;
    if (v[0]) return `RLSC_S_HOTRST;
    return `RLSC_S_U0;
endfunction
task warm; warm_reset_in = 1; tick(1); warm_reset_in = 0; chk("rxdet", `RLSC_S_RXDET, state_q); endtask
task to_idle(input logic [7:0] v);
    link_config = v;
    ssp_mode = $urandom;
    enter_tsx = 1; tick(1); enter_tsx = 0;
    chk("tsx", `RLSC_S_TSX, state_q);
    chk("raw", 1, forward_ts_raw_q);
    chk("comp", ssp_mode, comp_ssp_q);
    ts2_both_seen = 1; tick(1);
    chk("cfg timer", 1, cfg_timer_run_q);
    ts2_handshake = 1; tick(1); ts2_handshake = 0; ts2_both_seen = 0;
    chk("idle", `RLSC_S_IDLE, state_q);
    if (!ssp_mode) chk("idle del", 0, idle_delete_en_q);
    idle_handshake = 1; tick(1); idle_handshake = 0;
endtask
task to_u1; to_idle(0); lgo_u1_done = 1; tick(1); lgo_u1_done = 0; endtask
task complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
endtask
initial begin #(90000 * 50); fails++; complete_run; end
initial begin
    {enter_tsx, ts2_both_seen, ts2_handshake, ts1_seen, idle_handshake, lgo_u1_done} = 0;
    {lgo_u2_done, lgo_u3_done, lock_lost, lmp_init_seen, lmp_from_down, u2_lmp_acked} = 0;
    {lfps_active, lfps_is_ping, warm_reset_in, ping_on, resp_on, ssp_mode} = 0;
    {link_config, u2_lmp_value} = 0;
    polarity_done = 1;
    void'($urandom(32'haae8_7faf));
    tick(10);
    chk("reset state", `RLSC_S_RXDET, state_q);
    chk("reset term", 1, us_term_en_q & xcvr_enable_q & scrambler_en_q);
    rst_n = 1;
    foreach (lc[i]) begin
        lc = (i < 6) ? (8'h01 << i) : ($urandom & 8'h1d);
        to_idle(lc);
        chk("idle exit", exp_idle(lc), state_q);
        if (exp_idle(lc) == `RLSC_S_U0) chk("scr", !lc[3], scrambler_en_q);
        warm;
    end
    $display("test idle exits done");
    to_idle(0);
    chk("ecc", 1, err_correct_en_q);
    u2_lmp_value = $urandom; u2_lmp_acked = 1; lock_lost = 1;
    lmp_init_seen = 1; lmp_from_down = $urandom; tick(2);
    chk("hold u0", `RLSC_S_U0, state_q);
    chk("idles", 1, send_idles_q);
    chk("u2 tmo", u2_lmp_value, u2_timeout_q);
    chk("flip", lmp_from_down, port_flip_q);
    {u2_lmp_acked, lock_lost, u2_lmp_value, ts1_seen, lgo_u1_done} = 2'b00 << 8 | 10'h3;
    tick(1); {ts1_seen, lgo_u1_done} = 0;
    chk("rec", `RLSC_S_REC, state_q);
    warm;
    for (k = 0; k < 3; k++) begin
        to_idle(0);
        {lgo_u3_done, lgo_u2_done, lgo_u1_done} = 3'h7 << k; tick(1);
        {lgo_u3_done, lgo_u2_done, lgo_u1_done} = 0;
        chk("lgo", `RLSC_S_U1 << k, state_q);
        warm;
    end
    $display("test u0 done");
    to_u1;
    chk("ping tx", 1, ping_tx_en_q);
    ping_on = 1; tick(PING * 3); ping_on = 0;
    chk("pinged", `RLSC_S_U1, state_q);
    tick(PING / 2);
    chk("still u1", `RLSC_S_U1, state_q);
    wait_st(`RLSC_S_RXDET, PING);
    chk("term off", 0, us_term_en_q);
    chk("disc", 1, disconnect_q);
    chk("ping stop", 0, ping_tx_en_q);
    $display("test ping timeout done");
    to_u1;
    resp_on = 1; lfps_active = 1; tick(1);
    chk("exit tx", 1, exit_lfps_tx_q & lfps_forward_q);
    wait_st(`RLSC_S_REC, 4);
    {resp_on, lfps_active} = 0;
    warm;
    to_u1;
    lfps_active = 1; tick(WARM / 2);
    chk("fwd early", 1, lfps_forward_q);
    wait_st(`RLSC_S_RXDET, WARM + 4);
    lfps_active = 0;
    to_u1;
    lfps_active = 1; tick(3); lfps_active = 0; tick(NOL / 2);
    chk("wait resp", `RLSC_S_U1, state_q);
    wait_st(`RLSC_S_RXDET, NOL + 4);
    $display("test u1 exits done");
    u2_lmp_value = 8'h01;
    u2_lmp_acked = 1;
    to_u1;
    u2_lmp_acked = 0;
    ping_on = 1;
    chk("u2 set", 8'h01, u2_timeout_q);
    wait_st(`RLSC_S_U2, `RLSC_U2_UNIT + 8);
    ping_on = 0;
    warm;
    $display("test u2 inactivity done");
    enter_tsx = 1;
    tick(1);
    enter_tsx = 0;
    ts1_seen = 1;
    tick(1);
    ts1_seen = 0;
    wait_st(`RLSC_S_RXDET, ACT + 4);
    enter_tsx = 1;
    tick(1);
    enter_tsx = 0;
    ts2_handshake = 1;
    tick(1);
    ts2_handshake = 0;
    chk("idle wait", `RLSC_S_IDLE, state_q);
    wait_st(`RLSC_S_RXDET, IDL + 4);
    $display("test timeouts done");
    enter_tsx = 1; tick(1); enter_tsx = 0; tick(ACT * 2);
    chk("tsx kept", `RLSC_S_TSX, state_q);
    wait_st(`RLSC_S_ERR, ACT * 2);
    chk("xcvr off", 0, xcvr_enable_q);
    warm;
    $display("test error state done");
    complete_run;
end
endmodule
`default_nettype wire
